//--- src/dma_map.svh
// register offsets, field positions, reset values for the descriptor dma channel
// Notes on behaviour
// R1: descriptor is five words: head config, start page, start address, count, next pointer.
// R2: head ownership flag checked first; rest loaded only once set, else wait.
// R3: setting descriptor-ready makes the channel load the descriptor, then run it.
// R4: software writes descriptor words consecutively with ownership flag set.
// R5: after a transfer the channel clears the descriptor ownership flag.
// R6: standalone next pointer must address a zero word, not be address zero.
// R7: software writes head address to next-pointer register before ready.
// R8: software sets the run bit last, after the ready step.
// R9: after load and run bit, request bus; move data only while granted.
// R10: transfer status registers refresh every clock while active; here pointer and count step once per completed word.
// R11: at count zero write head back with count zero, ownership cleared.
// R12: completion interrupt only if the descriptor completion enable is set.
// R13: after completion fetch next head; zero word clears run bit and stops.
// R14: descriptor load plus start costs five reads and one write.
// R15: memory-to-memory channels offer no autobuffer mode.
// R16: autobuffer reloads setup on completion, repeats until run bit cleared.
// R17: autobuffer with interrupts enabled signals at half and at end.
// R18: software writes autobuffer select, then setup, then config with run.
// R19: completion and error interrupts recorded in config and interrupt status.
// R20: interrupt status holds two sticky bits cleared by writing one.
// R21: config register updated at transfer end before next descriptor load.
// R22: completion clears head ownership in memory and sets completion status.
// R23: config bit 0 run, bit 2 completion enable, bit 4 autobuffer, bit 15 owner.
// R24: config bit 14 reads zero after success, one after an error.
// R25: interrupt status bit 0 completion pending, bit 1 error pending.
// R26: each moved word advances the pointer and decrements the count.
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH
`define REG_PTR 3'h0
`define REG_CFG 3'h1
`define REG_SRP 3'h2
`define REG_SRA 3'h3
`define REG_CNT 3'h4
`define REG_CP 3'h5
`define REG_CPR 3'h6
`define REG_IRQ 3'h7
`define CFG_RUN 0
`define CFG_DIR 1
`define CFG_CIE 2
`define CFG_AUTO 4
`define CFG_EIE 8
`define CFG_ERR 14
`define CFG_OWN 15
`define IRQ_COMP 0
`define IRQ_ERR 1
`define SRP_SPACE 8
`define DESC_LAST 3'h4
`define CFG_RST 16'h0000
`define WORD_RST 16'h0000
`endif

//--- src/dma_pkg.sv
// types shared by the dma channel modules
package dma_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HEAD = 3'b001,
		ST_LOAD = 3'b010,
		ST_ARMED = 3'b011,
		ST_XFER = 3'b100,
		ST_BACK = 3'b101
	} chan_state_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic we;
		logic space;
		logic [7:0] page;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;
endpackage : dma_pkg

//--- src/dma_irq_status.sv
// sticky write-one-to-clear interrupt status of the channel
`timescale 1ns/1ps
`include "dma_map.svh"
module dma_irq_status (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic set_comp,
	input wire logic set_err,
	input wire logic clr_wr,
	input wire logic [1:0] clr_bits,
	output logic [1:0] pending_q,
	output logic irq_q
);
	logic [1:0] set_v;
	assign set_v = {set_err, set_comp};
	// a set in the clearing cycle survives
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pending_q <= 2'h0;
		end else begin
			pending_q <= (pending_q & ~(clr_wr ? clr_bits : 2'h0)) | set_v; // R20 R25
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |((pending_q & ~(clr_wr ? clr_bits : 2'h0)) | set_v);
		end
	end
endmodule : dma_irq_status

//--- src/dma_bus_master.sv
// one transaction at a time on the internal dma bus, request and grant
`timescale 1ns/1ps
`include "dma_map.svh"
module dma_bus_master (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic start,
	input dma_pkg::mem_req_t req,
	output logic done_q,
	output logic [15:0] rdata_q,
	output logic bus_req_q,
	input wire logic bus_gnt,
	output logic mem_stb_q,
	output dma_pkg::mem_req_t mem_q,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata
);
	import dma_pkg::*;
	logic issued_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bus_req_q <= 1'b0;
			issued_q <= 1'b0;
			mem_stb_q <= 1'b0;
			mem_q <= '0;
		end else begin
			mem_stb_q <= 1'b0;
			if (start) begin
				bus_req_q <= 1'b1;
				mem_q <= req;
			end else if (bus_req_q && bus_gnt && !issued_q) begin
				mem_stb_q <= 1'b1; // R9
				issued_q <= 1'b1;
			end else if (issued_q && mem_ack) begin
				issued_q <= 1'b0;
				bus_req_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			done_q <= 1'b0;
			rdata_q <= `WORD_RST;
		end else begin
			done_q <= issued_q && mem_ack;
			if (issued_q && mem_ack) begin
				rdata_q <= mem_rdata;
			end
		end
	end
endmodule : dma_bus_master

//--- src/dma_channel.sv
// descriptor-chained dma channel with autobuffer mode
`timescale 1ns/1ps
`include "dma_map.svh"
module dma_channel #(
	parameter bit MEM2MEM = 1'b0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input dma_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata_q,
	output logic bus_req_q,
	input wire logic bus_gnt,
	output logic mem_stb_q,
	output dma_pkg::mem_req_t mem_q,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire logic rx_valid,
	input wire logic [15:0] rx_data,
	output logic rx_take_q,
	output logic tx_valid_q,
	output logic [15:0] tx_data_q,
	input wire logic port_error,
	output logic irq_q
);
	import dma_pkg::*;

	chan_state_t state_q;
	logic [15:0] cfg_q;
	logic [8:0] srp_q;
	logic [15:0] sra_q;
	logic [15:0] cnt_q;
	logic [15:0] cp_q;
	logic [15:0] head_q;
	logic [15:0] ptr_q;
	logic [15:0] left_q;
	logic [2:0] idx_q;
	logic ready_q;
	logic err_q;
	logic busy_q;
	logic go;
	mem_req_t go_req;
	logic done;
	logic [15:0] rdata;
	logic [1:0] pending;
	logic set_comp;
	logic set_err;
	logic wr_cfg;
	logic auto_on;
	logic last_word;
	logic half_word;
	logic [15:0] back_word;

	function automatic mem_req_t mk_req(input logic we, input logic space,
		input logic [7:0] page, input logic [15:0] addr, input logic [15:0] wdata);
		mem_req_t r;
		r.we = we;
		r.space = space;
		r.page = page;
		r.addr = addr;
		r.wdata = wdata;
		return r;
	endfunction : mk_req

	assign wr_cfg = reg_req.wr && reg_req.addr == `REG_CFG;
	assign auto_on = cfg_q[`CFG_AUTO] && !MEM2MEM; // R15
	assign last_word = left_q == 16'h0001;
	// half point falls when the words still left equal half the count
	assign half_word = auto_on && cnt_q > 16'h0001 && (left_q - 16'h0001) == (cnt_q >> 1);
	// written head: count drained, ownership handed back, error status in place
	assign back_word = {1'b0, err_q, cfg_q[13:0]}; // R11 R5 R24

	// descriptors live on page 0 of data memory
	always_comb begin
		go = 1'b0;
		go_req = mk_req(1'b0, 1'b0, 8'h00, cp_q, `WORD_RST);
		case (state_q)
			ST_HEAD: begin
				go = !busy_q;
			end
			ST_LOAD: begin
				go = !busy_q;
				go_req = mk_req(1'b0, 1'b0, 8'h00, head_q + {13'h0, idx_q}, `WORD_RST); // R1
			end
			ST_XFER: begin
				// a memory write waits for the port to offer a word
				go = !busy_q && cfg_q[`CFG_RUN] && (!cfg_q[`CFG_DIR] || rx_valid); // R9
				go_req = mk_req(cfg_q[`CFG_DIR], srp_q[`SRP_SPACE], srp_q[7:0], ptr_q, rx_data);
			end
			ST_BACK: begin
				go = !busy_q;
				go_req = mk_req(1'b1, 1'b0, 8'h00, head_q, back_word); // R11 R14
			end
			default: begin
				go = 1'b0;
			end
		endcase
	end

	dma_bus_master u_bus (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(go),
		.req(go_req),
		.done_q(done),
		.rdata_q(rdata),
		.bus_req_q(bus_req_q),
		.bus_gnt(bus_gnt),
		.mem_stb_q(mem_stb_q),
		.mem_q(mem_q),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
		end else if (go) begin
			busy_q <= 1'b1;
		end else if (done) begin
			busy_q <= 1'b0;
		end
	end

	// descriptor ready: the take in idle loses to a fresh write
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ready_q <= 1'b0;
		end else if (reg_req.wr && reg_req.addr == `REG_CPR && reg_req.wdata[0]) begin
			ready_q <= 1'b1; // R3
		end else if (state_q == ST_IDLE) begin
			ready_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			idx_q <= 3'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (ready_q) begin
						state_q <= ST_HEAD; // R3
					end else if (auto_on && cfg_q[`CFG_RUN]) begin
						state_q <= ST_XFER; // R18
					end
				end
				ST_HEAD: begin
					if (done && rdata == `WORD_RST) begin
						state_q <= ST_IDLE; // R13
					end else if (done && rdata[`CFG_OWN]) begin
						state_q <= ST_LOAD; // R2
						idx_q <= 3'h1;
					end
				end
				ST_LOAD: begin
					if (done) begin
						idx_q <= idx_q + 3'h1;
						if (idx_q == `DESC_LAST) begin
							state_q <= ST_ARMED; // R14
						end
					end
				end
				ST_ARMED: begin
					if (cfg_q[`CFG_RUN]) begin
						state_q <= (cnt_q == `WORD_RST) ? ST_BACK : ST_XFER; // R9
					end
				end
				ST_XFER: begin
					if (!busy_q && !cfg_q[`CFG_RUN]) begin
						state_q <= ST_IDLE; // R16
					end else if (done && last_word && !auto_on) begin
						state_q <= ST_BACK; // R11
					end
				end
				ST_BACK: begin
					if (done) begin
						state_q <= ST_HEAD; // R13
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// software writes first, hardware updates after so they take effect
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= `CFG_RST;
		end else begin
			if (wr_cfg) begin
				cfg_q[`CFG_RUN] <= reg_req.wdata[`CFG_RUN];
				if (!MEM2MEM) begin
					cfg_q[`CFG_AUTO] <= reg_req.wdata[`CFG_AUTO]; // R15
				end
				// mode bits are writable only in autobuffer mode
				if ((reg_req.wdata[`CFG_AUTO] || cfg_q[`CFG_AUTO]) && !MEM2MEM) begin
					cfg_q[`CFG_DIR] <= reg_req.wdata[`CFG_DIR];
					cfg_q[`CFG_CIE] <= reg_req.wdata[`CFG_CIE];
					cfg_q[`CFG_EIE] <= reg_req.wdata[`CFG_EIE];
				end
			end
			if (state_q == ST_HEAD && done) begin
				if (rdata == `WORD_RST) begin
					cfg_q[`CFG_RUN] <= 1'b0; // R13
				end else if (rdata[`CFG_OWN]) begin
					cfg_q <= {rdata[15:5], rdata[4] && !MEM2MEM, rdata[3:1],
						cfg_q[`CFG_RUN] || (wr_cfg && reg_req.wdata[`CFG_RUN])}; // R23
				end
			end
			if (state_q == ST_BACK && done) begin
				cfg_q[`CFG_OWN] <= 1'b0; // R21 R22
				cfg_q[`CFG_ERR] <= err_q; // R24 R19
			end
			if (state_q == ST_XFER && done && last_word && auto_on) begin
				cfg_q[`CFG_ERR] <= err_q; // R24
			end
		end
	end

	// setup registers: loaded from the descriptor, or by software in autobuffer idle; next pointer by software any time
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			srp_q <= 9'h000;
			sra_q <= `WORD_RST;
			cnt_q <= `WORD_RST;
			cp_q <= `WORD_RST;
		end else begin
			if (reg_req.wr && reg_req.addr == `REG_CP) begin
				cp_q <= reg_req.wdata; // R7
			end
			if (reg_req.wr && auto_on && state_q == ST_IDLE) begin
				case (reg_req.addr)
					`REG_SRP: srp_q <= reg_req.wdata[8:0]; // R18
					`REG_SRA: sra_q <= reg_req.wdata;
					`REG_CNT: cnt_q <= reg_req.wdata;
					default: begin
					end
				endcase
			end
			if (state_q == ST_LOAD && done) begin
				case (idx_q)
					3'h1: srp_q <= rdata[8:0]; // R1
					3'h2: sra_q <= rdata;
					3'h3: cnt_q <= rdata;
					3'h4: cp_q <= rdata;
					default: begin
					end
				endcase
			end
		end
	end

	// live transfer status, stepped once per completed word while moving
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			head_q <= `WORD_RST;
			ptr_q <= `WORD_RST;
			left_q <= `WORD_RST;
		end else begin
			if (state_q == ST_HEAD && done) begin
				head_q <= cp_q;
			end
			if ((state_q == ST_ARMED && cfg_q[`CFG_RUN]) ||
				(state_q == ST_IDLE && !ready_q && auto_on && cfg_q[`CFG_RUN])) begin
				ptr_q <= sra_q;
				left_q <= cnt_q;
			end else if (state_q == ST_XFER && done) begin
				if (last_word && auto_on) begin
					ptr_q <= sra_q; // R16
					left_q <= cnt_q;
				end else begin
					ptr_q <= ptr_q + 16'h0001; // R26 R10
					left_q <= left_q - 16'h0001;
				end
			end
		end
	end

	// error seen in the running transfer; cleared as the next one starts
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			err_q <= 1'b0;
		end else if (state_q == ST_ARMED || (state_q == ST_IDLE && !ready_q)) begin
			err_q <= 1'b0;
		end else if (state_q == ST_XFER && port_error) begin
			err_q <= 1'b1; // R24
		end else if (state_q == ST_XFER && done && last_word && auto_on) begin
			err_q <= 1'b0;
		end
	end

	// port side: one word per memory transaction, taken as a write is requested, offered as a read completes
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_take_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_data_q <= `WORD_RST;
		end else begin
			rx_take_q <= state_q == ST_XFER && go && cfg_q[`CFG_DIR];
			tx_valid_q <= state_q == ST_XFER && done && !cfg_q[`CFG_DIR];
			if (state_q == ST_XFER && done && !cfg_q[`CFG_DIR]) begin
				tx_data_q <= rdata;
			end
		end
	end

	assign set_comp = cfg_q[`CFG_CIE] && ((state_q == ST_BACK && done) || // R12 R22
		(state_q == ST_XFER && done && auto_on && (last_word || half_word))); // R17
	assign set_err = state_q == ST_XFER && port_error && cfg_q[`CFG_EIE]; // R19

	dma_irq_status u_irq (
		.mclk(mclk),
		.rst_b(rst_b),
		.set_comp(set_comp),
		.set_err(set_err),
		.clr_wr(reg_req.wr && reg_req.addr == `REG_IRQ),
		.clr_bits(reg_req.wdata[1:0]),
		.pending_q(pending),
		.irq_q(irq_q)
	);

	// read data stand one cycle after the strobe and only then
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_q <= `WORD_RST;
		end else if (!reg_req.rd) begin
			reg_rdata_q <= `WORD_RST;
		end else begin
			case (reg_req.addr)
				`REG_PTR: reg_rdata_q <= ptr_q;
				`REG_CFG: reg_rdata_q <= cfg_q;
				`REG_SRP: reg_rdata_q <= {7'h00, srp_q};
				`REG_SRA: reg_rdata_q <= sra_q;
				`REG_CNT: reg_rdata_q <= (state_q == ST_XFER) ? left_q : cnt_q;
				`REG_CP: reg_rdata_q <= cp_q;
				`REG_CPR: reg_rdata_q <= {15'h0000, ready_q};
				`REG_IRQ: reg_rdata_q <= {14'h0000, pending}; // R25
				default: reg_rdata_q <= `WORD_RST;
			endcase
		end
	end
endmodule : dma_channel

//--- verif/dma_mem_model.sv
// memory and dma bus arbiter seen from the channel's bus side
`timescale 1ns/1ps
module dma_mem_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic bus_req,
	output logic bus_gnt,
	input wire logic mem_stb,
	input dma_pkg::mem_req_t mem,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	import dma_pkg::*;
	logic [15:0] ram [0:255];
	int n_rd = 0;
	int n_wr = 0;
	logic busy_q;
	logic [1:0] wait_q;
	mem_req_t cur_q;
	// grant lags request by a cycle; idle read data toggles so stale values never match
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bus_gnt <= 1'b0;
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
			busy_q <= 1'b0;
			wait_q <= 2'h0;
		end else begin
			bus_gnt <= bus_req;
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_stb) begin
				busy_q <= 1'b1;
				cur_q <= mem;
				wait_q <= slow ? 2'h3 : 2'h0;
			end else if (busy_q && wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				mem_ack <= 1'b1;
				if (cur_q.we) begin
					ram[cur_q.addr[7:0]] <= cur_q.wdata;
					n_wr <= n_wr + 1;
				end else begin
					mem_rdata <= ram[cur_q.addr[7:0]];
					n_rd <= n_rd + 1;
				end
			end
		end
	end
endmodule : dma_mem_model

//--- verif/dma_channel_props.sv
// port assertions for the dma channel
`timescale 1ns/1ps
`include "dma_map.svh"
module dma_channel_props (
	input wire logic mclk,
	input wire logic rst_b,
	input dma_pkg::reg_req_t reg_req,
	input wire logic [15:0] reg_rdata_q,
	input wire logic bus_req_q,
	input wire logic bus_gnt,
	input wire logic mem_stb_q,
	input dma_pkg::mem_req_t mem_q,
	input wire logic mem_ack,
	input wire logic tx_valid_q,
	input wire logic irq_q
);
	import dma_pkg::*;
	logic irq_wr;
	assign irq_wr = reg_req.wr && reg_req.addr == `REG_IRQ;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	sequence s_granted;
		bus_req_q && bus_gnt && $rose(bus_gnt);
	endsequence
	sequence s_quiet2;
		!mem_stb_q [*2];
	endsequence
	chk_stb_granted: assert property (mem_stb_q |-> $past(bus_req_q) && $past(bus_gnt))
		else $error("issue without grant");
	chk_grant_issue: assert property (s_granted |=> mem_stb_q)
		else $error("grant not followed by issue");
	chk_req_holds: assert property (bus_req_q && !mem_ack |=> bus_req_q)
		else $error("request dropped before ack");
	chk_stb_single: assert property (mem_stb_q |=> s_quiet2)
		else $error("issue pulse repeated");
	chk_ack_gap: assert property (mem_ack |=> s_quiet2)
		else $error("next issue too soon after ack");
	chk_mem_stable: assert property (bus_req_q && $past(bus_req_q) |-> $stable(mem_q))
		else $error("request changed while pending");
	chk_tx_after_ack: assert property (tx_valid_q |-> $past(mem_ack, 2))
		else $error("tx word without memory read");
	chk_tx_pulse: assert property (tx_valid_q |=> !tx_valid_q [*3])
		else $error("tx words too close");
	chk_irq_width: assert property (reg_req.rd && reg_req.addr == `REG_IRQ |=>
		reg_rdata_q[15:2] == 14'h0000)
		else $error("irq status wider than two bits");
	chk_irq_sticky: assert property (irq_q && !irq_wr |=> irq_q)
		else $error("pending interrupt lost");
endmodule : dma_channel_props
bind dma_channel dma_channel_props u_props (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
	.reg_rdata_q(reg_rdata_q), .bus_req_q(bus_req_q), .bus_gnt(bus_gnt),
	.mem_stb_q(mem_stb_q), .mem_q(mem_q), .mem_ack(mem_ack),
	.tx_valid_q(tx_valid_q), .irq_q(irq_q));

//--- verif/descriptor_chained_dma_channel_tb.sv
// self-checking bench for the descriptor dma channel
`timescale 1ns/1ps
`include "dma_map.svh"
module descriptor_chained_dma_channel_tb;
	import dma_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic slow = 1'b0;
	logic port_error = 1'b0;
	logic rx_valid = 1'b0;
	logic [15:0] rx_data = 16'h5A00;
	reg_req_t reg_req = '0;
	logic [15:0] reg_rdata_q, mem_rdata, tx_data_q;
	logic bus_req_q, bus_gnt, mem_stb_q, mem_ack, rx_take_q, tx_valid_q, irq_q;
	mem_req_t mem_q;
	int n_errors = 0;
	int num_checks = 0;
	int n_tx = 0;
	int n_rx = 0;
	int r0, w0, v;
	logic [15:0] txw [0:15];
	initial begin
		forever #5 mclk = ~mclk;
	end
	// port source: a fresh word after every take, held until it is taken
	dma_channel u_dma_channel (.mclk(mclk), .rst_b(rst_b), .reg_req(reg_req),
		.reg_rdata_q(reg_rdata_q), .bus_req_q(bus_req_q), .bus_gnt(bus_gnt),
		.mem_stb_q(mem_stb_q), .mem_q(mem_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_take_q(rx_take_q),
		.tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .port_error(port_error), .irq_q(irq_q));
	dma_mem_model u_mem (.mclk(mclk), .rst_b(rst_b), .slow(slow), .bus_req(bus_req_q),
		.bus_gnt(bus_gnt), .mem_stb(mem_stb_q), .mem(mem_q), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	always @(posedge mclk) begin
		if (tx_valid_q === 1'b1) begin
			txw[n_tx % 16] <= tx_data_q;
			n_tx <= n_tx + 1;
		end
		if (rx_take_q === 1'b1) begin
			rx_data <= rx_data + 16'h0001;
			n_rx <= n_rx + 1;
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		reg_req <= '0;
	endtask : wr
	task automatic rc(input string name, input logic [2:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		reg_req <= '0;
		#1 chk(name, reg_rdata_q, exp);
	endtask : rc
	task automatic wait_tx(input int n);
		for (int i = 0; i < 3000 && n_tx < n; i++) @(posedge mclk);
		if (n_tx < n) begin
			n_errors++;
			$display("[ERR] tx words expected %0d seen %0d", n, n_tx);
			summarize();
		end
	endtask : wait_tx
	task automatic put_desc(input int h, input logic [15:0] cfg, sra, cnt, cp);
		u_mem.ram[h] = cfg;
		u_mem.ram[h + 1] = 16'h0000;
		u_mem.ram[h + 2] = sra;
		u_mem.ram[h + 3] = cnt;
		u_mem.ram[h + 4] = cp;
		u_mem.ram[8'h20] = 16'h0000;
	endtask : put_desc
	task automatic go(input logic [15:0] head);
		r0 = u_mem.n_rd;
		w0 = u_mem.n_wr;
		n_tx = 0;
		wr(`REG_CP, head);
		wr(`REG_CPR, 16'h0001);
		wr(`REG_CFG, 16'h0001);
	endtask : go
	initial begin
		for (int i = 0; i < 256; i++) u_mem.ram[i] = 16'hA5A0 + 16'(i);
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		rc("ptr reset", `REG_PTR, 16'h0000);
		rc("cfg reset", `REG_CFG, 16'h0000);
		rc("irq reset", `REG_IRQ, 16'h0000);
		wr(`REG_SRA, 16'h1234);
		rc("sra locked", `REG_SRA, 16'h0000);
		put_desc(16'h10, 16'h8004, 16'h0040, 16'h0003, 16'h0020);
		go(16'h0010);
		wait_tx(3);
		repeat (30) @(posedge mclk);
		for (int i = 0; i < 3; i++) chk("tx word", txw[i], 16'hA5E0 + 16'(i));
		chk("head back", u_mem.ram[8'h10], 16'h0005);
		chk("reads", 16'(u_mem.n_rd - r0), 16'h0009);
		chk("writes", 16'(u_mem.n_wr - w0), 16'h0001);
		rc("cfg done", `REG_CFG, 16'h0004);
		rc("irq comp", `REG_IRQ, 16'h0001);
		wr(`REG_IRQ, 16'h0001);
		rc("irq clear", `REG_IRQ, 16'h0000);
		$display("test standalone done");
		slow <= 1'b1;
		put_desc(16'h10, 16'h8000, 16'h0050, 16'h0001, 16'h0018);
		put_desc(16'h18, 16'h0004, 16'h0060, 16'h0002, 16'h0020);
		go(16'h0010);
		wait_tx(1);
		repeat (150) @(posedge mclk);
		chk("no irq", irq_q, 16'h0000);
		chk("head a", u_mem.ram[8'h10], 16'h0001);
		chk("polling", 16'(n_tx), 16'h0001);
		u_mem.ram[8'h18] = 16'h8004;
		wait_tx(3);
		repeat (60) @(posedge mclk);
		chk("chain word", txw[2], 16'hA601);
		chk("head b", u_mem.ram[8'h18], 16'h0005);
		rc("irq chain", `REG_IRQ, 16'h0001);
		wr(`REG_IRQ, 16'h0001);
		slow <= 1'b0;
		$display("test chain done");
		put_desc(16'h10, 16'h8104, 16'h0040, 16'h0004, 16'h0020);
		go(16'h0010);
		wait_tx(1);
		port_error <= 1'b1;
		@(posedge mclk);
		port_error <= 1'b0;
		wait_tx(4);
		repeat (40) @(posedge mclk);
		rc("cfg error", `REG_CFG, 16'h4104);
		rc("irq both", `REG_IRQ, 16'h0003);
		chk("head error", u_mem.ram[8'h10], 16'h4105);
		wr(`REG_IRQ, 16'h0003);
		rc("irq both clear", `REG_IRQ, 16'h0000);
		$display("test error done");
		put_desc(16'h10, 16'h8006, 16'h0070, 16'h0002, 16'h0020);
		go(16'h0010);
		repeat (80) @(posedge mclk);
		chk("rx wait", 16'(n_rx), 16'h0000);
		rc("ptr start", `REG_PTR, 16'h0070);
		rc("cnt live", `REG_CNT, 16'h0002);
		rx_valid <= 1'b1;
		repeat (80) @(posedge mclk);
		chk("rx takes", 16'(n_rx), 16'h0002);
		chk("rx word 0", u_mem.ram[8'h70], 16'h5A00);
		chk("rx word 1", u_mem.ram[8'h71], 16'h5A01);
		chk("head rx", u_mem.ram[8'h10], 16'h0007);
		rc("ptr end", `REG_PTR, 16'h0072);
		rc("cfg rx", `REG_CFG, 16'h0006);
		rc("irq rx", `REG_IRQ, 16'h0001);
		wr(`REG_IRQ, 16'h0001);
		$display("test port write done");
		wr(`REG_CFG, 16'h0010);
		wr(`REG_SRP, 16'h0000);
		wr(`REG_SRA, 16'h0040);
		wr(`REG_CNT, 16'h0004);
		n_tx = 0;
		wr(`REG_CFG, 16'h0015);
		wait_tx(2);
		repeat (4) @(posedge mclk);
		chk("half irq", irq_q, 16'h0001);
		wr(`REG_IRQ, 16'h0001);
		wait_tx(4);
		repeat (4) @(posedge mclk);
		chk("end irq", irq_q, 16'h0001);
		wr(`REG_IRQ, 16'h0001);
		wait_tx(5);
		chk("wrap word", txw[4], 16'hA5E0);
		wr(`REG_CFG, 16'h0014);
		repeat (40) @(posedge mclk);
		v = n_tx;
		repeat (60) @(posedge mclk);
		chk("stopped", 16'(n_tx), 16'(v));
		$display("test autobuffer done");
		summarize();
	end
endmodule : descriptor_chained_dma_channel_tb
